// ---- src/gap_timer.sv ----
`timescale 1ns/100ps
module gap_timer
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Control
    input wire logic load,
    input wire logic [hostport_pkg::TMR_W-1:0] value,
    output logic done
);

    typedef struct packed {
        logic [hostport_pkg::TMR_W-1:0] cnt;
    } tmr_t;

    tmr_t t_reg;
    tmr_t t_next;

    always_comb
    begin
        t_next = t_reg;
        if (load)
        begin
            t_next.cnt = value;
        end
        else if (t_reg.cnt != '0)
        begin
            t_next.cnt = t_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            t_reg <= '0;
        end
        else if (ce)
        begin
            t_reg <= t_next;
        end
    end

    assign done = (t_reg.cnt == '0);

endmodule

// ---- src/host_serial_register_port.sv ----
`timescale 1ns/100ps
// What this block does
// - Every access opens with a 16-bit command word, MSB first.
// - Without address stepping, exactly one data word follows the command.
// - Read flag high selects a read; read data arrives MSB first.
// - Only one chained device may be selected during a read.
// - Writes keep an idle gap between command and data word.
// - The same gap separates consecutive write sequences.
// - Stepped writes keep the gap between consecutive data words.
// - Write gap depends on pixel clock; unlocked needs 100 ns; this block always uses the fixed 100 ns.
// - Reads wait after command and between words before the next burst.
// - Auxiliary packet buffer reads wait at least 222.6 ns per word.
// - Chip select stays low after last rising edge, 445 ns worst case.
module host_serial_register_port
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    // Access request
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic REQ_READ,
    input wire logic REQ_STEP,
    input wire logic REQ_AUX,
    input wire logic [hostport_pkg::ADDR_W-1:0] REQ_ADDR,
    input wire logic [hostport_pkg::COUNT_W-1:0] REQ_COUNT,
    // Write data
    input wire logic WR_VALID,
    input wire logic [hostport_pkg::WORD_W-1:0] WR_DATA,
    output logic WR_TAKEN,
    // Read data
    output logic RD_VALID,
    output logic [hostport_pkg::WORD_W-1:0] RD_DATA,
    output logic BUSY,
    // Device pins
    output logic SCLK,
    output logic CS_N,
    output logic SERIAL_IN,
    input wire logic SERIAL_OUT,
    output logic PORT_SEL
);

    typedef enum logic [2:0] {IDLE, SETUP, SHIFT, GAP, HOLD, REST} state_t;

    typedef struct packed {
        state_t state;
        logic sclk;
        logic cs_n;
        logic sdo;
        logic port_sel;
        logic [hostport_pkg::WORD_W-1:0] shreg;
        logic [hostport_pkg::WORD_W-1:0] rdata;
        logic [hostport_pkg::WORD_W-1:0] rd_out;
        logic [3:0] bitcnt;
        logic [2:0] phase;
        logic [hostport_pkg::COUNT_W:0] words;
        logic is_read;
        logic is_step;
        logic is_aux;
        logic is_cmd;
        logic rd_valid;
        logic wr_taken;
        logic req_ready;
        logic busy;
    } port_t;

    port_t s_reg;
    port_t s_next;
    logic tmr_load;
    logic [hostport_pkg::TMR_W-1:0] tmr_val;
    logic tmr_done;
    logic sdo_level;

    // Read data crosses in from the pin; the slow bit rate leaves room for the two stages
    pin_sync u_sync
    (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .ce(CLK_EN),
        .pin(SERIAL_OUT),
        .level(sdo_level)
    );

    gap_timer u_timer
    (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .ce(CLK_EN),
        .load(tmr_load),
        .value(tmr_val),
        .done(tmr_done)
    );

    always_comb
    begin
        s_next = s_reg;
        s_next.rd_valid = 1'b0;
        s_next.wr_taken = 1'b0;
        s_next.port_sel = hostport_pkg::RST_PORT_SEL;
        tmr_load = 1'b0;
        tmr_val = hostport_pkg::WR_GAP_CYC;
        case (s_reg.state)
            IDLE:
            begin
                s_next.req_ready = 1'b1;
                s_next.busy = 1'b0;
                if (REQ_VALID && s_reg.req_ready)
                begin
                    s_next.req_ready = 1'b0;
                    s_next.busy = 1'b1;
                    s_next.cs_n = 1'b0;
                    s_next.is_read = REQ_READ;
                    s_next.is_step = REQ_STEP;
                    s_next.is_aux = REQ_AUX;
                    s_next.is_cmd = 1'b1;
                    s_next.shreg = {REQ_READ, REQ_STEP, 2'h0, REQ_ADDR};
                    s_next.sdo = REQ_READ;
                    // A plain access carries exactly one data word
                    s_next.words = REQ_STEP ? ({1'b0, REQ_COUNT} + 9'h001) : 9'h001;
                    s_next.state = SETUP;
                end
            end
            SETUP:
            begin
                s_next.phase = 3'h0;
                s_next.bitcnt = 4'h0;
                s_next.state = SHIFT;
            end
            SHIFT:
            begin
                if (s_reg.phase == hostport_pkg::PH_LAST)
                begin
                    s_next.sclk = 1'b0;
                    s_next.phase = 3'h0;
                    if (s_reg.is_read && !s_reg.is_cmd)
                    begin
                        s_next.rdata = {s_reg.rdata[14:0], sdo_level};
                    end
                    if (s_reg.bitcnt == hostport_pkg::LAST_BIT)
                    begin
                        s_next.sdo = 1'b0;
                        tmr_load = 1'b1;
                        if (s_reg.is_cmd)
                        begin
                            s_next.is_cmd = 1'b0;
                            s_next.state = GAP;
                            if (s_reg.is_read)
                            begin
                                tmr_val = s_reg.is_aux ? hostport_pkg::AUX_GAP_CYC
                                                       : hostport_pkg::RD_GAP_CYC;
                            end
                            else
                            begin
                                tmr_val = hostport_pkg::WR_GAP_CYC;
                            end
                        end
                        else
                        begin
                            s_next.words = s_reg.words - 9'h001;
                            if (s_reg.is_read)
                            begin
                                s_next.rd_out = {s_reg.rdata[14:0], sdo_level};
                                s_next.rd_valid = 1'b1;
                            end
                            if (s_reg.words == 9'h001)
                            begin
                                tmr_val = hostport_pkg::CS_HOLD_CYC;
                                s_next.state = HOLD;
                            end
                            else
                            begin
                                // Device steps the address itself; no new command
                                if (s_reg.is_read)
                                begin
                                    tmr_val = s_reg.is_aux ? hostport_pkg::AUX_GAP_CYC
                                                           : hostport_pkg::RD_GAP_CYC;
                                end
                                else
                                begin
                                    tmr_val = hostport_pkg::WR_GAP_CYC;
                                end
                                s_next.state = GAP;
                            end
                        end
                    end
                    else
                    begin
                        s_next.bitcnt = s_reg.bitcnt + 4'h1;
                        s_next.shreg = {s_reg.shreg[14:0], 1'b0};
                        s_next.sdo = s_reg.shreg[14];
                    end
                end
                else
                begin
                    s_next.phase = s_reg.phase + 3'h1;
                    if (s_reg.phase + 3'h1 == hostport_pkg::PH_RISE)
                    begin
                        s_next.sclk = 1'b1;
                    end
                end
            end
            GAP:
            begin
                if (tmr_done)
                begin
                    if (s_reg.is_read)
                    begin
                        s_next.shreg = '0;
                        s_next.sdo = 1'b0;
                        s_next.phase = 3'h0;
                        s_next.bitcnt = 4'h0;
                        s_next.state = SHIFT;
                    end
                    else if (WR_VALID)
                    begin
                        s_next.shreg = WR_DATA;
                        s_next.sdo = WR_DATA[15];
                        s_next.wr_taken = 1'b1;
                        s_next.phase = 3'h0;
                        s_next.bitcnt = 4'h0;
                        s_next.state = SHIFT;
                    end
                end
            end
            HOLD:
            begin
                if (tmr_done)
                begin
                    s_next.cs_n = 1'b1;
                    tmr_load = 1'b1;
                    tmr_val = hostport_pkg::WR_GAP_CYC;
                    s_next.state = REST;
                end
            end
            REST:
            begin
                if (tmr_done)
                begin
                    s_next.req_ready = 1'b1;
                    s_next.state = IDLE;
                end
            end
            default:
            begin
                s_next.state = IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            s_reg <= '0;
            s_reg.state <= IDLE;
            s_reg.cs_n <= hostport_pkg::RST_CS_N;
            s_reg.sclk <= hostport_pkg::RST_SCLK;
            s_reg.port_sel <= hostport_pkg::RST_PORT_SEL;
        end
        else if (CLK_EN)
        begin
            s_reg <= s_next;
        end
    end

    assign REQ_READY = s_reg.req_ready;
    assign WR_TAKEN = s_reg.wr_taken;
    assign RD_VALID = s_reg.rd_valid;
    assign RD_DATA = s_reg.rd_out;
    assign BUSY = s_reg.busy;
    assign SCLK = s_reg.sclk;
    assign CS_N = s_reg.cs_n;
    assign SERIAL_IN = s_reg.sdo;
    assign PORT_SEL = s_reg.port_sel;

    // Helper counters watched only by the checks below
    logic [7:0] low_run;
    logic [7:0] since_rise;
    logic [8:0] data_words;

    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            low_run <= 8'h00;
            since_rise <= 8'h00;
            data_words <= 9'h000;
        end
        else if (CLK_EN)
        begin
            low_run <= s_next.sclk ? 8'h00 : ((low_run == 8'hff) ? low_run : low_run + 8'h01);
            since_rise <= (s_next.sclk && !s_reg.sclk) ? 8'h00
                        : ((since_rise == 8'hff) ? since_rise : since_rise + 8'h01);
            if (s_reg.state == IDLE)
            begin
                data_words <= 9'h000;
            end
            else if (s_reg.state == SHIFT && s_next.state != SHIFT && !s_reg.is_cmd)
            begin
                data_words <= data_words + 9'h001;
            end
        end
    end

    sequence word_start_s;
        $rose(SCLK) && s_reg.bitcnt == 4'h0 && !s_reg.is_cmd;
    endsequence
    sequence cs_release_s;
        $rose(CS_N);
    endsequence
    cmd_layout_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        s_reg.state == SETUP |-> s_reg.shreg[hostport_pkg::CMD_RW_BIT] == s_reg.is_read
            && s_reg.shreg[hostport_pkg::CMD_STEP_BIT] == s_reg.is_step
            && s_reg.shreg[13:12] == 2'h0)
        else $error("command word fields misplaced");
    msb_first_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        $rose(SCLK) && (s_reg.is_cmd || !s_reg.is_read) |-> SERIAL_IN == s_reg.shreg[15])
        else $error("serial bit not the word's top bit at rising edge");
    burst_clock_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        CS_N |-> !SCLK)
        else $error("serial clock runs while deselected");
    write_gap_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        word_start_s and !s_reg.is_read |-> $past(low_run) >= 8'(hostport_pkg::WR_GAP_CYC))
        else $error("write word started before the idle gap");
    read_gap_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        word_start_s and s_reg.is_read && !s_reg.is_aux
            |-> $past(low_run) >= 8'(hostport_pkg::RD_GAP_CYC))
        else $error("read word started before the wait");
    aux_gap_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        word_start_s and s_reg.is_read && s_reg.is_aux
            |-> $past(low_run) >= 8'(hostport_pkg::AUX_GAP_CYC))
        else $error("buffer read word started too early");
    cs_hold_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        cs_release_s |-> $past(since_rise) >= 8'(hostport_pkg::CS_HOLD_CYC))
        else $error("chip select raised too soon after last rise");
    seq_gap_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        cs_release_s ##1 CLK_EN |-> CS_N[*3])
        else $error("next access began inside the idle gap");
    one_word_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        s_reg.state == HOLD && !s_reg.is_step |-> data_words == 9'h001)
        else $error("plain access sent other than one data word");
    read_result_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        RD_VALID |-> s_reg.is_read && !$past(s_reg.is_cmd) && $past(s_reg.bitcnt) == 4'hf)
        else $error("read result without a full read word");
    port_select_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        !PORT_SEL)
        else $error("port select left the serial host port");
endmodule

// ---- src/hostport_pkg.sv ----
package hostport_pkg;

    // Word layout
    localparam int WORD_W = 16;
    localparam int ADDR_W = 12;
    localparam int COUNT_W = 8;
    localparam int CMD_RW_BIT = 15;
    localparam int CMD_STEP_BIT = 14;
    localparam int TMR_W = 4;

    // Core clock period and link gaps, all in tenths of a nanosecond
    localparam int CORE_PERIOD_X10 = 400;
    localparam int WR_GAP_X10 = 1000;
    localparam int RD_GAP_X10 = 1484;
    localparam int AUX_GAP_X10 = 2226;
    localparam int CS_HOLD_X10 = 4450;

    // Least times round up to whole core cycles
    localparam logic [TMR_W-1:0] WR_GAP_CYC =
        TMR_W'((WR_GAP_X10 + CORE_PERIOD_X10 - 1) / CORE_PERIOD_X10);
    localparam logic [TMR_W-1:0] RD_GAP_CYC =
        TMR_W'((RD_GAP_X10 + CORE_PERIOD_X10 - 1) / CORE_PERIOD_X10);
    localparam logic [TMR_W-1:0] AUX_GAP_CYC =
        TMR_W'((AUX_GAP_X10 + CORE_PERIOD_X10 - 1) / CORE_PERIOD_X10);
    localparam logic [TMR_W-1:0] CS_HOLD_CYC =
        TMR_W'((CS_HOLD_X10 + CORE_PERIOD_X10 - 1) / CORE_PERIOD_X10);

    // Serial clock: six core cycles per bit, three low then three high
    localparam logic [2:0] PH_RISE = 3'h3;
    localparam logic [2:0] PH_LAST = 3'h5;
    localparam logic [3:0] LAST_BIT = 4'hf;

    // Values after reset
    localparam logic RST_CS_N = 1'b1;
    localparam logic RST_SCLK = 1'b0;
    localparam logic RST_PORT_SEL = 1'b0;

endpackage

// ---- src/pin_sync.sv ----
`timescale 1ns/100ps
module pin_sync
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Pin
    input wire logic pin,
    output logic level
);

    typedef struct packed {
        logic first;
        logic second;
    } sync_t;

    sync_t s_reg;
    sync_t s_next;

    always_comb
    begin
        s_next = s_reg;
        s_next.first = pin;
        s_next.second = s_reg.first;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_reg <= '0;
        end
        else if (ce)
        begin
            s_reg <= s_next;
        end
    end

    assign level = s_reg.second;

endmodule

// ---- testbench/serial_device_model.sv ----
`timescale 1ns/100ps
module serial_device_model
#(
    parameter logic [11:0] AUX_BASE = 12'h800
)
(
    // Device pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_in,
    output logic serial_out,
    input wire logic port_sel,
    // Host timing faults seen
    output int viol_count
);
    logic [15:0] mem [0:4095];
    logic [15:0] in_sr;
    logic [15:0] out_sr;
    logic [15:0] cmd;
    logic [11:0] addr;
    int bit_cnt;
    int word_cnt;
    logic reading;
    realtime last_rise;
    realtime last_fall;
    realtime gap;

    initial
    begin
        for (int i = 0; i < 4096; i++)
            mem[i] = 16'(i) ^ 16'h3c00;
        viol_count = 0;
        bit_cnt = 0;
        word_cnt = 0;
        reading = 1'b0;
        out_sr = 16'h0000;
        in_sr = 16'h0000;
        cmd = 16'h0000;
        addr = 12'h000;
        last_rise = 0.0;
        last_fall = -1000.0;
    end

    // Deselected, the line shows the inverse so a stale level cannot pass
    assign serial_out = cs_n ? ~serial_in : (reading ? out_sr[15] : serial_in);

    always @(posedge sclk)
    begin
        if (cs_n || port_sel)
            viol_count++;
        else
        begin
            if (bit_cnt == 0)
            begin
                gap = (word_cnt > 0 && cmd[15]) ? ((addr >= AUX_BASE) ? 222.6 : 148.4) : 100.0;
                if ($realtime - last_fall < gap)
                    viol_count++;
                if (word_cnt > 1 && !cmd[14])
                    viol_count++;
            end
            in_sr = {in_sr[14:0], serial_in};
            bit_cnt++;
            last_rise = $realtime;
            if (bit_cnt == 16)
            begin
                bit_cnt = 0;
                if (word_cnt == 0)
                begin
                    cmd = in_sr;
                    addr = in_sr[11:0];
                    reading = in_sr[15];
                end
                else if (!cmd[15])
                begin
                    mem[addr] = in_sr;
                    if (cmd[14])
                        addr++;
                end
                word_cnt++;
            end
        end
    end

    // Output settles a little after the fall, as a real part would
    always @(negedge sclk)
    begin
        last_fall = $realtime;
        if (!cs_n && reading)
        begin
            #10;
            if (bit_cnt == 0)
            begin
                if (word_cnt > 1 && cmd[14])
                    addr++;
                out_sr = mem[addr];
            end
            else
                out_sr = out_sr << 1;
        end
    end

    always @(posedge cs_n)
    begin
        if ((word_cnt > 0 || bit_cnt > 0) && $realtime - last_rise < 445.0)
            viol_count++;
        if (bit_cnt != 0)
            viol_count++;
        bit_cnt = 0;
        word_cnt = 0;
        reading = 1'b0;
    end
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/100ps
module tb;
    typedef struct packed {
        logic rd;
        logic step;
        logic aux;
        logic [11:0] addr;
        logic [7:0] count;
        logic [15:0] wbase;
        logic [7:0] stall;
    } row_t;

    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic req_valid = 1'b0;
    logic req_read = 1'b0;
    logic req_step = 1'b0;
    logic req_aux = 1'b0;
    logic [11:0] req_addr = 12'h000;
    logic [7:0] req_count = 8'h00;
    logic wr_valid = 1'b0;
    logic [15:0] wr_data = 16'h0000;
    logic req_ready, wr_taken, rd_valid, busy, sclk, cs_n, serial_in, serial_out, port_sel;
    logic [15:0] rd_data;
    logic [15:0] shadow [0:4095];
    int viol;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [2:0] frozen;
    row_t rows [9] = '{
        '{1'b0, 1'b0, 1'b0, 12'h010, 8'h00, 16'ha55a, 8'h00},
        '{1'b1, 1'b0, 1'b0, 12'h010, 8'h00, 16'h0000, 8'h00},
        '{1'b0, 1'b1, 1'b0, 12'h0fe, 8'h02, 16'h1234, 8'h00},
        '{1'b1, 1'b1, 1'b0, 12'h0fe, 8'h02, 16'h0000, 8'h00},
        '{1'b0, 1'b0, 1'b0, 12'hfff, 8'h05, 16'hbeef, 8'h00},
        '{1'b1, 1'b0, 1'b0, 12'hfff, 8'h05, 16'h0000, 8'h00},
        '{1'b1, 1'b1, 1'b1, 12'h800, 8'h01, 16'h0000, 8'h00},
        '{1'b0, 1'b1, 1'b0, 12'h020, 8'h01, 16'h0f0f, 8'hc8},
        '{1'b1, 1'b1, 1'b0, 12'h020, 8'h01, 16'h0000, 8'h00}
    };

    host_serial_register_port i_dut (
        .CORE_CLK(core_clk), .SYS_RST(sys_rst), .CLK_EN(clk_en),
        .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_READ(req_read),
        .REQ_STEP(req_step), .REQ_AUX(req_aux), .REQ_ADDR(req_addr), .REQ_COUNT(req_count),
        .WR_VALID(wr_valid), .WR_DATA(wr_data), .WR_TAKEN(wr_taken),
        .RD_VALID(rd_valid), .RD_DATA(rd_data), .BUSY(busy),
        .SCLK(sclk), .CS_N(cs_n), .SERIAL_IN(serial_in), .SERIAL_OUT(serial_out),
        .PORT_SEL(port_sel)
    );

    serial_device_model i_dev (
        .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .serial_out(serial_out),
        .port_sel(port_sel), .viol_count(viol)
    );

    initial
    begin
        forever #20 core_clk = ~core_clk;
    end

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Checks made: %0d, mismatches: %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic reset_check();
        @(negedge core_clk);
        sys_rst = 1'b1;
        repeat (12) @(negedge core_clk);
        check_bit(cs_n, 1'b1);
        check_bit(sclk, 1'b0);
        check_bit(port_sel, 1'b0);
        check_bit(req_ready, 1'b0);
        check_bit(busy, 1'b0);
        check_word(rd_data, 16'h0000);
        sys_rst = 1'b0;
        repeat (3) @(negedge core_clk);
        check_bit(req_ready, 1'b1);
    endtask

    // Called at a falling edge; request held until the edge that takes it
    task automatic do_access(input row_t r);
        int words;
        int k;
        int t;
        int stall_left;
        logic [11:0] a;
        words = r.step ? int'(r.count) + 1 : 1;
        k = 0;
        t = 0;
        a = r.addr;
        stall_left = int'(r.stall);
        req_valid = 1'b1;
        req_read = r.rd;
        req_step = r.step;
        req_aux = r.aux;
        req_addr = r.addr;
        req_count = r.count;
        wr_data = r.wbase;
        wr_valid = !r.rd && stall_left == 0;
        while (req_ready !== 1'b1)
            @(negedge core_clk);
        @(negedge core_clk);
        req_valid = 1'b0;
        check_bit(busy, 1'b1);
        check_bit(cs_n, 1'b0);
        while ((t < 3 || req_ready !== 1'b1) && t < 4000)
        begin
            @(negedge core_clk);
            t++;
            if (wr_taken === 1'b1)
            begin
                shadow[a] = wr_data;
                a++;
                k++;
                wr_data = r.wbase + 16'(k) * 16'h0101;
                stall_left = int'(r.stall);
                wr_valid = k < words && stall_left == 0;
            end
            else if (!r.rd && k < words && stall_left > 0)
            begin
                stall_left--;
                if (stall_left == 0)
                begin
                    check_bit(sclk, 1'b0);
                    check_bit(cs_n, 1'b0);
                    wr_valid = 1'b1;
                end
            end
            if (rd_valid === 1'b1)
            begin
                check_word(rd_data, shadow[a]);
                a++;
                k++;
            end
        end
        check_word(16'(k), 16'(words));
        check_bit(cs_n, 1'b1);
        for (int i = 0; i < words + 1; i++)
            check_word(i_dev.mem[12'(r.addr + i)], shadow[12'(r.addr + i)]);
    endtask

    initial
    begin
        for (int i = 0; i < 4096; i++)
            shadow[i] = 16'(i) ^ 16'h3c00;
        reset_check();
        for (int i = 0; i < 9; i++)
            do_access(rows[i]);
        // Freeze mid-command; three cycles is one serial half period, so a live clock shows
        fork
            do_access(rows[0]);
            begin
                repeat (30) @(negedge core_clk);
                frozen = {sclk, cs_n, serial_in};
                clk_en = 1'b0;
                repeat (3) @(negedge core_clk);
                check_word(16'({sclk, cs_n, serial_in}), 16'(frozen));
                clk_en = 1'b1;
            end
        join
        reset_check();
        do_access(rows[3]);
        check_word(16'(viol), 16'h0000);
        print_verdict();
    end

    // Whole run is near 3500 cycles; the ceiling leaves ample margin
    initial
    begin
        forever
        begin
            @(posedge core_clk);
            cycles++;
            if (cycles == 30000)
            begin
                mismatches++;
                print_verdict();
            end
        end
    end
endmodule
